// >>> logic/rtpp_pkg.sv
package rtpp_pkg;
    // framing constants
    localparam logic [7:0]  SYNC_BYTE            = 8'h55;
    localparam logic [7:0]  HEADER_CHECKSUM_OFS  = 8'h05;
    // packet types and fixed optional lengths
    localparam logic [7:0]  TYPE_SHORT           = 8'h01;
    localparam logic [7:0]  TYPE_GEN2            = 8'h0a;
    localparam logic [7:0]  TYPE_MESSAGE         = 8'h09;
    localparam logic [7:0]  TYPE_RESPONSE        = 8'h02;
    localparam logic [7:0]  TYPE_EVENT           = 8'h04;
    localparam logic [7:0]  OPT_LEN_SHORT        = 8'h07;
    localparam logic [7:0]  OPT_LEN_GEN2         = 8'h02;
    localparam logic [7:0]  OPT_LEN_MESSAGE      = 8'h0a;
    // payload limits
    localparam logic [15:0] MAX_SHORT_BROADCAST  = 16'h000e;
    localparam logic [15:0] MAX_SHORT_ADDRESSED  = 16'h0009;
    localparam logic [15:0] MAX_GEN2_FRAME       = 16'h00ff;
    localparam logic [15:0] MAX_MESSAGE_BUFFER   = 16'h0098;
    // destination offset inside the optional data
    localparam logic [7:0]  DEST_FIRST_SHORT     = 8'h01;
    localparam logic [7:0]  DEST_FIRST_MESSAGE   = 8'h00;
    // return and event codes
    localparam logic [7:0]  RETURN_SUCCESS       = 8'h00;
    localparam logic [7:0]  RETURN_UNSUPPORTED   = 8'h02;
    localparam logic [7:0]  RETURN_BAD_PARAMETER = 8'h03;
    localparam logic [7:0]  RETURN_DUTY_LOCKED   = 8'h05;
    localparam logic [7:0]  TRANSMIT_DONE_EVENT  = 8'h08;
    // answer packet layout
    localparam logic [7:0]  ANSWER_LEN           = 8'h08;

    // answer request handed to the serial sender
    typedef struct packed {
        logic [7:0] packet_type;
        logic [7:0] code;
    } rtpp_answer_type;

    // telegram start handed to the radio path
    typedef struct packed {
        logic [1:0]  format;
        logic        broadcast;
        logic [15:0] length;
    } rtpp_tx_type;
endpackage

// >>> logic/rtpp_parser.sv
// Notes on behaviour
// - short packet: opt length 7, type 0x01
// - header checksum at offset 5 after sync
// - data checksum covers data and optional data
// - short payload over 14/9 gives code 0x03
// - destination all ones means broadcast
// - security-level byte is ignored
// - good short packet answers success 00
// - duty lock answers 05, no transmit
// - finished transmission sends event 0x08
// - 868 variant answers gen2 with 02
// - 902 variant accepts short and gen2
// - gen2 telegram checksum byte not checked
// - gen2 payload limited to 255 bytes
// - message packet type 0x09, ten opt bytes
// - message payload limited to 152 bytes
`timescale 1ns/1ps
module rtpp_parser #(
    parameter bit IS_902 = 1'b0  // high on the 902 MHz variant
) (
    // clock, reset, enable
    input  wire logic                 mclk,
    input  wire logic                 sys_rst,
    input  wire logic                 clk_en,
    // serial bytes from host
    input  wire logic                 rx_valid,
    input  wire logic [7:0]           rx_byte,
    // radio side
    input  wire logic                 duty_locked,
    input  wire logic                 tx_finished,
    input  wire logic                 tx_busy,
    output rtpp_pkg::rtpp_tx_type     tx_req,
    output logic                      tx_start,
    output logic                      tx_data_valid,
    output logic [7:0]                tx_data,
    // answers to host
    output rtpp_pkg::rtpp_answer_type answer,
    output logic                      answer_valid,
    output logic                      checksum_error
);
    // parser states
    typedef enum logic [2:0] {
        ST_SYNC   = 3'b000,
        ST_HEADER = 3'b001,
        ST_DATA   = 3'b010,
        ST_OPT    = 3'b011,
        ST_CHECK  = 3'b100
    } rtpp_state_type;

    // crc8 step, polynomial x^8+x^2+x+1, used for both checksums
    function automatic logic [7:0] crc_step(input logic [7:0] crc, input logic [7:0] din);
        logic [7:0] c;
        c = crc ^ din;
        for (int i = 0; i < 8; i++) begin
            c = c[7] ? ((c << 1) ^ 8'h07) : (c << 1);
        end
        return c;
    endfunction
    rtpp_state_type      state;        // parser state
    rtpp_state_type      next_state;
    logic [15:0]         count;        // byte index within the section
    logic [15:0]         next_count;
    logic [15:0]         data_len;     // data length field
    logic [15:0]         next_data_len;
    logic [7:0]          opt_len;      // optional length field
    logic [7:0]          next_opt_len;
    logic [7:0]          ptype;        // packet type field
    logic [7:0]          next_ptype;
    logic [7:0]          crc;          // running checksum
    logic [7:0]          next_crc;
    logic                bcast;        // destination still all ones
    logic                next_bcast;
    logic                pending;      // accepted telegram awaiting done
    logic                next_pending;
    logic                owed, next_owed; // done event held back one cycle by a response
    rtpp_pkg::rtpp_answer_type next_answer;
    logic                next_answer_valid;
    logic                next_checksum_error;
    rtpp_pkg::rtpp_tx_type next_tx_req;
    logic                next_tx_start;
    logic                next_tx_data_valid;
    logic [7:0]          next_tx_data;
    logic [7:0]          dest_first;   // first destination byte index
    logic [15:0]         limit;        // payload ceiling for this format
    logic                known;        // recognised format

    // format decode from type byte and optional length
    always_comb begin
        known      = 1'b1;
        dest_first = rtpp_pkg::DEST_FIRST_SHORT;
        limit      = rtpp_pkg::MAX_GEN2_FRAME;
        if (ptype == rtpp_pkg::TYPE_SHORT && opt_len == rtpp_pkg::OPT_LEN_SHORT) begin
            limit = bcast ? rtpp_pkg::MAX_SHORT_BROADCAST : rtpp_pkg::MAX_SHORT_ADDRESSED;
        end else if (ptype == rtpp_pkg::TYPE_GEN2 && opt_len == rtpp_pkg::OPT_LEN_GEN2) begin
            limit = rtpp_pkg::MAX_GEN2_FRAME;
        end else if (ptype == rtpp_pkg::TYPE_MESSAGE && opt_len == rtpp_pkg::OPT_LEN_MESSAGE) begin
            limit      = rtpp_pkg::MAX_MESSAGE_BUFFER;
            dest_first = rtpp_pkg::DEST_FIRST_MESSAGE;
        end else begin
            known = 1'b0;
        end
    end
    // parser next-state
    always_comb begin
        next_state          = state;
        next_count          = count;
        next_data_len       = data_len;
        next_opt_len        = opt_len;
        next_ptype          = ptype;
        next_crc            = crc;
        next_bcast          = bcast;
        next_pending        = pending;
        next_owed           = 1'b0;
        next_answer         = answer;
        next_answer_valid   = 1'b0;
        next_checksum_error = 1'b0;
        next_tx_req         = tx_req;
        next_tx_start       = 1'b0;
        next_tx_data_valid  = 1'b0;
        next_tx_data        = rx_byte;
        if ((tx_finished && pending) || owed) begin
            next_pending      = 1'b0;
            next_answer       = '{rtpp_pkg::TYPE_EVENT, rtpp_pkg::TRANSMIT_DONE_EVENT};
            next_answer_valid = 1'b1;
        end
        if (rx_valid) begin
            case (state)
                ST_SYNC: begin
                    next_count = 16'h0000;
                    next_crc   = 8'h00;
                    next_bcast = 1'b1;
                    if (rx_byte == rtpp_pkg::SYNC_BYTE) begin
                        next_state = ST_HEADER;
                    end
                end
                ST_HEADER: begin
                    next_crc   = crc_step(crc, rx_byte);
                    next_count = count + 16'h0001;
                    case (count[2:0])
                        3'h0: next_data_len = {rx_byte, 8'h00};
                        3'h1: next_data_len = {data_len[15:8], rx_byte};
                        3'h2: next_opt_len  = rx_byte;
                        3'h3: next_ptype    = rx_byte;
                        default: begin
                            next_count = 16'h0000;
                            next_crc   = 8'h00;
                            if (crc != rx_byte) begin
                                next_state          = ST_SYNC;
                                next_checksum_error = 1'b1;
                            end else begin
                                next_state = (data_len != 16'h0000) ? ST_DATA : (opt_len == 8'h00) ? ST_CHECK : ST_OPT;
                            end
                        end
                    endcase
                end
                ST_DATA: begin
                    next_crc           = crc_step(crc, rx_byte);
                    next_count         = count + 16'h0001;
                    next_tx_data_valid = 1'b1;
                    if (next_count == data_len) begin
                        next_count = 16'h0000;
                        next_state = (opt_len == 8'h00) ? ST_CHECK : ST_OPT;
                    end
                end
                ST_OPT: begin
                    next_crc   = crc_step(crc, rx_byte);
                    next_count = count + 16'h0001;
                    // any non-FF destination byte means addressed
                    if (ptype != rtpp_pkg::TYPE_GEN2 && count[7:0] >= dest_first
                        && count[7:0] < dest_first + 8'h04 && rx_byte != 8'hff) begin
                        next_bcast = 1'b0;
                    end
                    if (next_count[7:0] == opt_len) begin
                        next_state = ST_CHECK;
                    end
                end
                default: begin
                    next_state = ST_SYNC;
                    if (crc != rx_byte) begin
                        next_checksum_error = 1'b1;
                    end else begin
                        next_owed         = next_answer_valid; // an event due now goes out next cycle
                        next_answer_valid = 1'b1;
                        next_answer       = '{rtpp_pkg::TYPE_RESPONSE, rtpp_pkg::RETURN_SUCCESS};
                        if (!known) begin
                            next_answer.code = rtpp_pkg::RETURN_BAD_PARAMETER;
                        // gen2 only on the 902 variant
                        end else if (ptype == rtpp_pkg::TYPE_GEN2 && !IS_902) begin
                            next_answer.code = rtpp_pkg::RETURN_UNSUPPORTED;
                        end else if (data_len > limit) begin
                            next_answer.code = rtpp_pkg::RETURN_BAD_PARAMETER;
                        end else if (duty_locked || tx_busy || pending) begin
                            next_answer.code = rtpp_pkg::RETURN_DUTY_LOCKED;
                        end else begin
                            // short, gen2 and message all start here
                            // gen2 telegram checksum byte passed raw
                            next_tx_start = 1'b1;
                            next_pending  = 1'b1;
                            next_tx_req   = '{{ptype[3], ptype[0]}, bcast, data_len}; // bits 3,0 keep formats apart
                        end
                    end
                end
            endcase
        end
    end

    // register all parser state
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state          <= ST_SYNC;
            count          <= 16'h0000;
            data_len       <= 16'h0000;
            opt_len        <= 8'h00;
            ptype          <= 8'h00;
            crc            <= 8'h00;
            bcast          <= 1'b1;
            pending        <= 1'b0;
            owed           <= 1'b0;
            answer         <= '0;
            answer_valid   <= 1'b0;
            checksum_error <= 1'b0;
            tx_req         <= '0;
            tx_start       <= 1'b0;
            tx_data_valid  <= 1'b0;
            tx_data        <= 8'h00;
        end else if (clk_en) begin
            state          <= next_state;
            count          <= next_count;
            data_len       <= next_data_len;
            opt_len        <= next_opt_len;
            ptype          <= next_ptype;
            crc            <= next_crc;
            bcast          <= next_bcast;
            pending        <= next_pending;
            owed           <= next_owed;
            answer         <= next_answer;
            answer_valid   <= next_answer_valid;
            checksum_error <= next_checksum_error;
            tx_req         <= next_tx_req;
            tx_start       <= next_tx_start;
            tx_data_valid  <= next_tx_data_valid;
            tx_data        <= next_tx_data;
        end
    end
    AST_LOCK_NO_TX: assert property (@(posedge mclk) disable iff (sys_rst)
        answer_valid && answer.code == rtpp_pkg::RETURN_DUTY_LOCKED |-> !tx_start)
        else $error("radio started on refused request");
    AST_START_SUCCESS: assert property (@(posedge mclk) disable iff (sys_rst)
        tx_start |-> answer_valid && answer.code == rtpp_pkg::RETURN_SUCCESS)
        else $error("start without success answer");
    AST_SHORT_LIMIT: assert property (@(posedge mclk) disable iff (sys_rst)
        tx_start && tx_req.format == 2'b01 |-> tx_req.length <= (tx_req.broadcast ? 16'h000e : 16'h0009))
        else $error("oversize short telegram started");
    AST_MSG_LIMIT: assert property (@(posedge mclk) disable iff (sys_rst)
        tx_start && tx_req.format == 2'b11 |-> tx_req.length <= 16'h0098) else $error("oversize message started");
    AST_GEN2_VARIANT: assert property (@(posedge mclk) disable iff (sys_rst)
        tx_start && tx_req.format == 2'b10 |-> IS_902) else $error("gen2 started on 868 variant");
    AST_BAD_SILENT: assert property (@(posedge mclk) disable iff (sys_rst)
        checksum_error |-> !tx_start && !(answer_valid && answer.packet_type == rtpp_pkg::TYPE_RESPONSE))
        else $error("radio started or answered on bad checksum");
    // done event within two cycles of finish
    AST_DONE_EVENT: assert property (@(posedge mclk) disable iff (sys_rst)
        clk_en && tx_finished && pending |-> ##[1:2] answer_valid && answer.code == rtpp_pkg::TRANSMIT_DONE_EVENT)
        else $error("done event missing");
    // sync byte in sync state goes to header
    AST_SYNC_HUNT: assert property (@(posedge mclk) disable iff (sys_rst)
        clk_en && rx_valid && state == ST_SYNC && rx_byte == 8'h55 |=> state == ST_HEADER)
        else $error("sync byte not taken");
endmodule

// >>> tb/rtpp_host_model.sv
`timescale 1ns/1ps
module rtpp_host_model (
    // clock
    input  wire logic mclk,
    // serial bytes toward the parser
    output logic       rx_valid,
    output logic [7:0] rx_byte
);
    logic [7:0] frame [$]; // whole frame, sync to data checksum

    // idle line at time zero
    initial begin
        rx_valid = 1'b0;
        rx_byte  = 8'h00;
    end

    // crc8, polynomial 0x07, one byte folded in
    function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] b);
        logic [7:0] r;
        r = c ^ b;
        for (int i = 0; i < 8; i++) begin
            r = r[7] ? ({r[6:0], 1'b0} ^ 8'h07) : {r[6:0], 1'b0};
        end
        return r;
    endfunction

    // builds one transmit request; bad[0] spoils header crc, bad[1] data crc
    task automatic send(input logic [7:0] typ, input logic [15:0] dlen, input logic bc, input logic [1:0] bad);
        logic [7:0] ch;
        logic [7:0] cd;
        logic [7:0] d;
        logic [7:0] opt [$];
        ch = 8'h00;
        cd = 8'h00;
        d  = bc ? 8'hff : 8'h81;
        case (typ)
            8'h01:   opt = {8'h03, d, d, d, d, 8'hff, 8'h00};
            8'h0a:   opt = {8'h03, 8'hff};
            default: opt = {d, d, d, d, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00};
        endcase
        // header crc over bytes 1 to 4
        frame = {8'h55, dlen[15:8], dlen[7:0], 8'(opt.size()), typ};
        for (int i = 1; i < 5; i++) begin
            ch = crc8(ch, frame[i]);
        end
        frame.push_back(ch ^ {7'h00, bad[0]});
        // data crc covers data then optional data
        for (int i = 0; i < int'(dlen); i++) begin
            frame.push_back(8'(i) + 8'h20);
            cd = crc8(cd, 8'(i) + 8'h20);
        end
        foreach (opt[i]) begin
            frame.push_back(opt[i]);
            cd = crc8(cd, opt[i]);
        end
        frame.push_back(cd ^ {7'h00, bad[1]});
        // bytes back to back, one per edge
        foreach (frame[i]) begin
            @(posedge mclk);
            rx_valid <= 1'b1;
            rx_byte  <= frame[i];
        end
        @(posedge mclk);
        rx_valid <= 1'b0;
        // released line must not look like the last byte
        rx_byte  <= ~frame[frame.size() - 1];
    endtask
endmodule

// >>> tb/tb.sv
`timescale 1ns/1ps
module tb;
    logic                      mclk        = 1'b0; // 20 MHz clock
    logic                      sys_rst     = 1'b1; // sync reset
    logic                      duty_locked = 1'b0; // limiter lock
    logic                      tx_finished = 1'b0; // radio done pulse
    logic                      clk_en      = 1'b1; // clock enable
    logic                      tx_busy     = 1'b0; // radio busy level
    logic                      tx_data_valid;      // data byte strobe
    logic [7:0]                tx_data;            // data byte
    logic [7:0]                dat_q;              // last data byte
    logic                      rx_valid;           // host strobe
    logic [7:0]                rx_byte;            // host byte
    logic                      tx_start;           // telegram start
    logic                      answer_valid;       // answer strobe
    logic                      answer9_valid;      // 902 answer strobe
    logic                      checksum_error;     // crc fault pulse
    rtpp_pkg::rtpp_tx_type     tx_req;             // start fields
    rtpp_pkg::rtpp_tx_type     req_q;              // fields at last start
    rtpp_pkg::rtpp_answer_type answer;             // 868 answer
    rtpp_pkg::rtpp_answer_type answer9;            // 902 answer
    rtpp_pkg::rtpp_answer_type ans_q;              // last 868 answer
    rtpp_pkg::rtpp_answer_type ans9_q;             // last 902 answer
    int                        fail_count  = 0;    // mismatches
    int                        tests_run   = 0;    // comparisons
    int                        ans_cnt     = 0;    // answers seen
    int                        start_cnt   = 0;    // starts seen
    int                        err_cnt     = 0;    // crc faults seen
    int                        dat_cnt     = 0;    // data bytes seen
    int                        cycles      = 0;    // timeout counter

    // clock
    always #25 mclk = ~mclk;

    rtpp_host_model host_u (.mclk(mclk), .rx_valid(rx_valid), .rx_byte(rx_byte));
    rtpp_parser #(.IS_902(1'b0)) dut_u (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .rx_valid(rx_valid),
        .rx_byte(rx_byte), .duty_locked(duty_locked), .tx_finished(tx_finished), .tx_busy(tx_busy),
        .tx_req(tx_req), .tx_start(tx_start), .tx_data_valid(tx_data_valid), .tx_data(tx_data), .answer(answer),
        .answer_valid(answer_valid), .checksum_error(checksum_error));
    // second variant sees the same traffic, only its answers are judged
    rtpp_parser #(.IS_902(1'b1)) dut9_u (.mclk(mclk), .sys_rst(sys_rst), .clk_en(clk_en), .rx_valid(rx_valid),
        .rx_byte(rx_byte), .duty_locked(duty_locked), .tx_finished(tx_finished), .tx_busy(tx_busy),
        .tx_req(), .tx_start(), .tx_data_valid(), .tx_data(), .answer(answer9),
        .answer_valid(answer9_valid), .checksum_error());

    // one-cycle pulses are caught in the cycle they stand
    always @(posedge mclk) begin
        cycles++;
        if (answer_valid === 1'b1) begin
            ans_cnt++;
            ans_q = answer;
        end
        if (answer9_valid === 1'b1) begin
            ans9_q = answer9;
        end
        if (tx_start === 1'b1) begin
            start_cnt++;
            req_q = tx_req;
        end
        if (checksum_error === 1'b1) begin
            err_cnt++;
        end
        if (tx_data_valid === 1'b1) begin
            dat_cnt++;
            dat_q = tx_data;
        end
        if (cycles == 30000) begin
            fail_count++;
            $display("BAD %0t timeout", $time);
            end_of_test();
        end
    end

    task automatic chk(input logic ok, input string what);
        tests_run++;
        if (ok !== 1'b1) begin
            fail_count++;
            $display("BAD %0t %s", $time, what);
        end
    endtask

    // one request, then its answer (or silence for a spoiled frame)
    task automatic req(input logic [7:0] typ, input logic [15:0] len, input logic bc, input logic [1:0] bad,
                       input logic [7:0] code, input logic go);
        int a;
        int s;
        int e;
        int d;
        a = ans_cnt;
        s = start_cnt;
        e = err_cnt;
        d = dat_cnt;
        host_u.send(typ, len, bc, bad);
        for (int i = 0; i < 8 && ans_cnt == a; i++) begin
            @(posedge mclk);
        end
        repeat (2) @(posedge mclk);
        if (bad != 2'b00) begin
            chk(err_cnt == e + 1 && ans_cnt == a, "spoiled frame answered");
        end else begin
            chk(ans_cnt == a + 1 && ans_q.packet_type === 8'h02 && ans_q.code === code, "return code");
            chk((start_cnt == s + 1) == go, "transmit start");
            chk(dat_cnt == d + int'(len) && dat_q === 8'(len - 16'd1) + 8'h20, "data stream");
            if (go) begin
                chk(req_q.length === len && req_q.format === ((typ == 8'h09) ? 2'b11 : typ[1:0])
                    && req_q.broadcast === bc, "start fields");
            end
        end
    endtask

    // radio reports done, done event expected
    task automatic ev();
        int a;
        a = ans_cnt;
        tx_finished <= 1'b1;
        @(posedge mclk);
        tx_finished <= 1'b0;
        repeat (4) @(posedge mclk);
        chk(ans_cnt == a + 1 && ans_q.packet_type === 8'h04 && ans_q.code === 8'h08, "done event");
    endtask

    task automatic t_short();
        req(8'h01, 16'd14, 1'b1, 2'b00, 8'h00, 1'b1);
        req(8'h01, 16'd4, 1'b1, 2'b00, 8'h05, 1'b0);  // busy while pending
        ev();
        req(8'h01, 16'd15, 1'b1, 2'b00, 8'h03, 1'b0);
        req(8'h01, 16'd9, 1'b0, 2'b00, 8'h00, 1'b1);
        ev();
        req(8'h01, 16'd10, 1'b0, 2'b00, 8'h03, 1'b0);
        $display("test short done");
    endtask

    task automatic t_lock();
        duty_locked <= 1'b1;
        req(8'h01, 16'd4, 1'b1, 2'b00, 8'h05, 1'b0);
        duty_locked <= 1'b0;
        $display("test lock done");
    endtask

    task automatic t_msg();
        req(8'h09, 16'd152, 1'b1, 2'b00, 8'h00, 1'b1);
        ev();
        req(8'h09, 16'd153, 1'b1, 2'b00, 8'h03, 1'b0);
        req(8'h09, 16'd20, 1'b0, 2'b00, 8'h00, 1'b1);
        ev();
        $display("test message done");
    endtask

    task automatic t_gen2();
        req(8'h0a, 16'd255, 1'b1, 2'b00, 8'h02, 1'b0);
        chk(ans9_q.code === 8'h00 && ans9_q.packet_type === 8'h02, "gen2 on 902");
        tx_finished <= 1'b1;
        @(posedge mclk);
        tx_finished <= 1'b0;
        repeat (4) @(posedge mclk);
        chk(ans9_q.packet_type === 8'h04 && ans9_q.code === 8'h08, "gen2 done event");
        $display("test gen2 done");
    endtask

    task automatic t_crc();
        req(8'h01, 16'd4, 1'b1, 2'b01, 8'h00, 1'b0);
        req(8'h01, 16'd4, 1'b1, 2'b10, 8'h00, 1'b0);
        req(8'h01, 16'd4, 1'b1, 2'b00, 8'h00, 1'b1);
        ev();
        $display("test checksum done");
    endtask

    // busy radio, unknown type, frozen clock enable, reset while pending
    task automatic t_hold();
        int a;
        int s;
        tx_busy <= 1'b1;
        req(8'h01, 16'd4, 1'b1, 2'b00, 8'h05, 1'b0);
        tx_busy <= 1'b0;
        req(8'h05, 16'd4, 1'b1, 2'b00, 8'h03, 1'b0);
        clk_en <= 1'b0;
        a = ans_cnt;
        s = start_cnt;
        host_u.send(8'h01, 16'd4, 1'b1, 2'b00);
        repeat (4) @(posedge mclk);
        clk_en <= 1'b1;
        chk(ans_cnt == a && start_cnt == s, "frozen parser reacted");
        req(8'h01, 16'd4, 1'b1, 2'b00, 8'h00, 1'b1);
        sys_rst <= 1'b1;
        @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        chk(answer_valid === 1'b0 && tx_start === 1'b0, "outputs after second reset");
        req(8'h01, 16'd4, 1'b1, 2'b00, 8'h00, 1'b1);
        ev();
        $display("test hold done");
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (8) @(posedge mclk);
        sys_rst <= 1'b0;
        @(posedge mclk);
        chk(answer_valid === 1'b0 && tx_start === 1'b0 && checksum_error === 1'b0, "outputs after reset");
        t_short();
        t_lock();
        t_msg();
        t_gen2();
        t_crc();
        t_hold();
        end_of_test();
    end
endmodule
